// [hw/atd_cfg.svh]
`ifndef ATD_CFG_SVH
`define ATD_CFG_SVH

// ============================================================
// Instruction word and register widths
`define ATD_INSTR_W 10
`define ATD_ACC_W 4
`define ATD_Z_W 2
`define ATD_D_W 3

// ============================================================
// Opcodes of this transfer group
`define ATD_OP_ACC_FROM_TC1 10'h24B
`define ATD_OP_ACC_FROM_TC2 10'h24C
`define ATD_OP_ACC_FROM_TC6 10'h250
`define ATD_OP_ACC_FROM_X 10'h054
`define ATD_OP_ACC_FROM_Y 10'h01F
`define ATD_OP_ACC_FROM_Z 10'h057
`define ATD_OP_ACC_TO_B 10'h00F
`define ATD_OP_ACC_TO_D 10'h029

// ============================================================
// Reset values
`define ATD_ACC_RST 4'h0
`define ATD_B_RST 4'h0
`define ATD_D_RST 3'h0

`endif

// [hw/atd_pkg.sv]
`include "atd_cfg.svh"

package atd_pkg;

    // ============================================================
    // Decoded operation
    typedef enum logic [3:0] {
        ATD_OP_NONE = 4'h0,
        ATD_OP_TC1 = 4'h1,
        ATD_OP_TC2 = 4'h3,
        ATD_OP_TC6 = 4'h2,
        ATD_OP_X = 4'h6,
        ATD_OP_Y = 4'h7,
        ATD_OP_Z = 4'h5,
        ATD_OP_B = 4'h4,
        ATD_OP_D = 4'hC
    } atd_op_t;

    // ============================================================
    // Source registers seen by the decoder
    typedef struct packed {
        logic [`ATD_ACC_W-1:0] timer_control_one;
        logic [`ATD_ACC_W-1:0] timer_control_two;
        logic [`ATD_ACC_W-1:0] timer_control_six;
        logic [`ATD_ACC_W-1:0] x_reg;
        logic [`ATD_ACC_W-1:0] y_reg;
        logic [`ATD_Z_W-1:0] z_reg;
        logic [`ATD_ACC_W-1:0] acc;
    } atd_src_t;

    // ============================================================
    // Write-back requests toward the core
    typedef struct packed {
        logic acc_we;
        logic [`ATD_ACC_W-1:0] acc_data;
        logic b_we;
        logic [`ATD_ACC_W-1:0] b_data;
        logic d_we;
        logic [`ATD_D_W-1:0] d_data;
        logic hit;
    } atd_wb_t;

endpackage : atd_pkg

// [hw/atd_opcode_match.sv]
`timescale 1ns/1ps
`include "atd_cfg.svh"

module atd_opcode_match
    import atd_pkg::*;
(
    input wire logic [`ATD_INSTR_W-1:0] instr,
    output atd_op_t op
);

    // ============================================================
    // Full-width compare, nothing else in this group may alias
    always_comb begin
        case (instr)
            `ATD_OP_ACC_FROM_TC1: op = ATD_OP_TC1;
            `ATD_OP_ACC_FROM_TC2: op = ATD_OP_TC2;
            `ATD_OP_ACC_FROM_TC6: op = ATD_OP_TC6;
            `ATD_OP_ACC_FROM_X: op = ATD_OP_X;
            `ATD_OP_ACC_FROM_Y: op = ATD_OP_Y;
            `ATD_OP_ACC_FROM_Z: op = ATD_OP_Z;
            `ATD_OP_ACC_TO_B: op = ATD_OP_B;
            `ATD_OP_ACC_TO_D: op = ATD_OP_D;
            default: op = ATD_OP_NONE;
        endcase
    end

endmodule : atd_opcode_match

// [hw/atd_accumulator_transfer_decode.sv]
// Behaviour
// - opcode 24B loads accumulator from timer control one
// - opcode 24C loads accumulator from timer control two
// - opcode 250 loads accumulator from timer control six
// - X register copied into accumulator
// - Y register copied into accumulator
// - Z into acc low bits, upper cleared
// - accumulator copied into register B
// - accumulator bits 2..0 into port select register
`timescale 1ns/1ps
`include "atd_cfg.svh"

module atd_accumulator_transfer_decode
    import atd_pkg::*;
#(
    parameter int INSTR_W = `ATD_INSTR_W,
    parameter int ACC_W = `ATD_ACC_W,
    parameter int Z_W = `ATD_Z_W,
    parameter int D_W = `ATD_D_W
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire atd_src_t src,
    output atd_wb_t wb,
    output logic carry_flag_we,
    output logic skip_req
);

    // ============================================================
    // Parameter checks
    // The carrier structs fix every field width, so a parameter may
    // only restate it; any other value would cut or pad bits
    if (INSTR_W != `ATD_INSTR_W) begin : g_bad_instr_w
        $error("INSTR_W must match the instruction word width");
    end
    if (ACC_W != `ATD_ACC_W) begin : g_bad_acc_w
        $error("ACC_W must match the accumulator width");
    end
    if (Z_W != `ATD_Z_W || Z_W >= ACC_W) begin : g_bad_z_w
        $error("Z_W must match the Z register and stay below ACC_W");
    end
    if (D_W != `ATD_D_W || D_W > ACC_W) begin : g_bad_d_w
        $error("D_W must match the port select register and fit ACC_W");
    end

    // ============================================================
    // Decode state
    // Next values are decoded per concern; each has its own flop below
    atd_op_t op;
    logic word_taken;
    logic acc_we_next;
    logic [ACC_W-1:0] acc_data_next;
    logic acc_we_reg;
    logic [ACC_W-1:0] acc_data_reg;
    logic b_we_next;
    logic [ACC_W-1:0] b_data_next;
    logic b_we_reg;
    logic [ACC_W-1:0] b_data_reg;
    logic d_we_next;
    logic [D_W-1:0] d_data_next;
    logic d_we_reg;
    logic [D_W-1:0] d_data_reg;
    logic hit_reg;

    // ============================================================
    // Opcode match
    // The valid qualifier is applied after the match, so a stale word
    // left on an idle bus never raises a request
    atd_opcode_match u_match (
        .instr(instr),
        .op(op)
    );

    assign word_taken = instr_valid && (op != ATD_OP_NONE);

    // ============================================================
    // Accumulator loads
    // Z is narrower than the accumulator; its missing high bits load as zero
    always_comb begin
        acc_we_next = 1'b0;
        acc_data_next = `ATD_ACC_RST;
        if (instr_valid) begin
            case (op)
                ATD_OP_TC1: begin
                    acc_we_next = 1'b1;
                    acc_data_next = src.timer_control_one;
                end
                ATD_OP_TC2: begin
                    acc_we_next = 1'b1;
                    acc_data_next = src.timer_control_two;
                end
                ATD_OP_TC6: begin
                    acc_we_next = 1'b1;
                    acc_data_next = src.timer_control_six;
                end
                ATD_OP_X: begin
                    acc_we_next = 1'b1;
                    acc_data_next = src.x_reg;
                end
                ATD_OP_Y: begin
                    acc_we_next = 1'b1;
                    acc_data_next = src.y_reg;
                end
                ATD_OP_Z: begin
                    acc_we_next = 1'b1;
                    acc_data_next = {{(ACC_W-Z_W){1'b0}}, src.z_reg};
                end
                default: begin
                    acc_we_next = 1'b0;
                    acc_data_next = `ATD_ACC_RST;
                end
            endcase
        end
    end

    // ============================================================
    // Register B store
    // The whole accumulator is copied; B has the same width
    always_comb begin
        b_we_next = 1'b0;
        b_data_next = `ATD_B_RST;
        if (instr_valid && op == ATD_OP_B) begin
            b_we_next = 1'b1;
            b_data_next = src.acc;
        end
    end

    // ============================================================
    // Port select register store, fed by the low accumulator bits only
    always_comb begin
        d_we_next = 1'b0;
        d_data_next = `ATD_D_RST;
        if (instr_valid && op == ATD_OP_D) begin
            d_we_next = 1'b1;
            d_data_next = src.acc[D_W-1:0];
        end
    end

    // ============================================================
    // Accumulator write strobe
    // One pulse per accumulator load word; the core commits it on the next edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_we_reg <= 1'b0;
        end else begin
            acc_we_reg <= acc_we_next;
        end
    end

    // ============================================================
    // Accumulator write data
    // Zero without its strobe, so the core may OR the requests of all groups
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_data_reg <= `ATD_ACC_RST;
        end else begin
            acc_data_reg <= acc_data_next;
        end
    end

    // ============================================================
    // Register B write request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b_we_reg <= 1'b0;
            b_data_reg <= `ATD_B_RST;
        end else begin
            b_we_reg <= b_we_next;
            b_data_reg <= b_data_next;
        end
    end

    // ============================================================
    // Port select register write request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_we_reg <= 1'b0;
            d_data_reg <= `ATD_D_RST;
        end else begin
            d_we_reg <= d_we_next;
            d_data_reg <= d_data_next;
        end
    end

    // ============================================================
    // Hit flag
    // Marks that this group claimed the word, so no other group acts on it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= word_taken;
        end
    end

    // ============================================================
    // This group never touches carry and never skips, so these stay low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_flag_we <= 1'b0;
            skip_req <= 1'b0;
        end else begin
            carry_flag_we <= 1'b0;
            skip_req <= 1'b0;
        end
    end

    // ============================================================
    // Outputs, each field straight from its flop
    always_comb begin
        wb.acc_we = acc_we_reg;
        wb.acc_data = acc_data_reg;
        wb.b_we = b_we_reg;
        wb.b_data = b_data_reg;
        wb.d_we = d_we_reg;
        wb.d_data = d_data_reg;
        wb.hit = hit_reg;
    end

endmodule : atd_accumulator_transfer_decode

// [verif/atd_accumulator_transfer_decode_asserts.sv]
`timescale 1ns/1ps
module atd_chk
    import atd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [9:0] instr,
    input wire atd_src_t src,
    input wire atd_wb_t wb,
    input wire logic carry_flag_we,
    input wire logic skip_req
);
    wire logic [10:0] vw = {instr_valid, instr};
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_tc1_load: assert property (vw == 11'h64B
        |=> wb.acc_we && wb.acc_data == $past(src.timer_control_one)) else $error("tc1");
    a_tc2_load: assert property (vw == 11'h64C
        |=> wb.acc_we && wb.acc_data == $past(src.timer_control_two)) else $error("tc2");
    a_tc6_load: assert property (vw == 11'h650
        |=> wb.acc_we && wb.acc_data == $past(src.timer_control_six)) else $error("tc6");
    a_x_load: assert property (vw == 11'h454
        |=> wb.acc_we && wb.acc_data == $past(src.x_reg)) else $error("x");
    a_y_load: assert property (vw == 11'h41F
        |=> wb.acc_we && wb.acc_data == $past(src.y_reg)) else $error("y");
    a_z_load: assert property (vw == 11'h457
        |=> wb.acc_we && wb.acc_data == {2'h0, $past(src.z_reg)}) else $error("z");
    a_b_store: assert property (vw == 11'h40F
        |=> wb.b_we && wb.b_data == $past(src.acc)) else $error("b");
    a_d_store: assert property (vw == 11'h429
        |=> wb.d_we && wb.d_data == $past(src.acc[2:0])) else $error("d");
    a_foreign_idle: assert property (!(vw inside {11'h64B, 11'h64C, 11'h650, 11'h454,
        11'h41F, 11'h457, 11'h40F, 11'h429}) |=> wb == '0) else $error("idle");
    a_carry_kept: assert property (!carry_flag_we) else $error("carry written");
    a_never_skip: assert property (!skip_req) else $error("skip requested");
endmodule : atd_chk
bind atd_accumulator_transfer_decode atd_chk atd_chk_i (.clk, .arst_n, .instr_valid, .instr,
    .src, .wb, .carry_flag_we, .skip_req);

// [verif/atd_accumulator_transfer_decode_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected %0t %h %h", $time, a, b); end
module atd_accumulator_transfer_decode_tb
    import atd_pkg::*;;
    logic clk = 1'h0, arst_n = 1'h0, instr_valid = 1'h0, carry_flag_we, skip_req;
    logic [9:0] instr = 10'h000, op [8] = '{10'h24B, 10'h24C, 10'h250, 10'h054, 10'h01F,
        10'h057, 10'h00F, 10'h029};
    logic [31:0] seed = 32'h39;
    atd_src_t src = '0;
    atd_wb_t wb, e, got, expq[$];
    int num_errors = 0, n_tests = 0;
    always #2 clk = ~clk;
    atd_accumulator_transfer_decode atd_accumulator_transfer_decode_i (.clk, .arst_n,
        .instr_valid, .instr, .src, .wb, .carry_flag_we, .skip_req);
    function automatic logic [31:0] xorshift(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic put(logic v, logic [9:0] i);
        @(negedge clk);
        seed = xorshift(seed);
        instr_valid = v;
        instr = i;
        src = seed[25:0];
        e = atd_wb_t'(1);
        case (i)
            10'h24B: e[14:10] = {1'h1, src.timer_control_one};
            10'h24C: e[14:10] = {1'h1, src.timer_control_two};
            10'h250: e[14:10] = {1'h1, src.timer_control_six};
            10'h054: e[14:10] = {1'h1, src.x_reg};
            10'h01F: e[14:10] = {1'h1, src.y_reg};
            10'h057: e[14:10] = {3'h4, src.z_reg};
            10'h00F: e[9:5] = {1'h1, src.acc};
            10'h029: e[4:1] = {1'h1, src.acc[2:0]};
            default: e.hit = 1'h0;
        endcase
        expq.push_back(v ? e : atd_wb_t'(0));
    endtask : put
    always @(posedge clk) begin
        #1;
        if (expq.size() != 0) begin
            got = expq.pop_front();
            `CHK({wb, carry_flag_we, skip_req}, {got, 2'h0})
        end
    end
    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'h1;
        // Random words and one-bit neighbours probe the full ten-bit compare
        for (int r = 0; r < 210; r++)
            put(r % 7 != 6, r % 13 == 12 ? seed[9:0] :
                r % 11 == 10 ? op[r % 8] ^ (10'h001 << (r % 10)) : op[r % 8]);
        // A reset in mid-run must drop a standing write request at once
        put(1'h1, op[0]);
        @(negedge clk);
        arst_n = 1'h0;
        #1 `CHK({wb, carry_flag_we, skip_req}, 17'h0)
        @(negedge clk);
        arst_n = 1'h1;
        put(1'h1, op[6]);
        @(negedge clk);
        if (expq.size() != 0)
            num_errors++;
        tally_and_finish();
    end
endmodule : atd_accumulator_transfer_decode_tb
